// ### verilog/rbseq_top.sv
// Functional notes
// R1 - External reset is active low, enters at once, and leaves only on a clock edge.
// R2 - The board keeps the clock running ten cycles before the reset rising edge.
// R3 - The first fetch request comes exactly eighty cycles after the reset rising edge.
// R4 - The clock output is low in reset and copies the clock afterwards unless reassigned.
// R5 - Any reset restores peripheral defaults and forces the next fetch to address zero.
// R6 - A watchdog reset acts like external reset but keeps the latched strap modes.
// R7 - External reset wins over a simultaneous watchdog reset.
// R8 - Tri-state strap low for the final ten cycles before release disables all outputs; the code only latches tristate_mode and gates no output.
// R9 - The board holds the tri-state strap high throughout a normal reset.
// R10 - After reset all peripheral pins are configured as inputs.
// R11 - Boot-width strap sampled in the final ten cycles; high is 8-bit, low is 16-bit.
// R12 - A memory remap is cleared only by an internal or external reset.
// R13 - Latched strap modes hold until the next external reset release resamples them.
`timescale 1ns/10ps
module rbseq_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic ext_reset_n,
	input wire logic tristate_strap_n,
	input wire logic boot_width_strap,
	input wire logic watchdog_unit_reset,
	input wire logic remap_cmd,
	input wire logic clk_out_reassign,
	output logic master_clk_out,
	output logic periph_reset,
	output logic fetch_start,
	output logic fetch_addr_zero,
	output logic tristate_mode,
	output logic boot_8bit,
	output logic remap_active,
	output logic pins_as_inputs
);
	typedef struct packed {
		logic tri_s1;
		logic tri_s2;
		logic bw_s1;
		logic bw_s2;
		logic ext_prev;
		logic [3:0] tri_low_cnt;
		logic bw_last;
		logic tri_mode;
		logic bw_mode;
		logic [6:0] cnt;
		rbseq_pkg::rbseq_state_t st;
		logic fetch;
		logic remap;
		logic clk_gate;
	} rbseq_regs_t;

	rbseq_regs_t r;
	rbseq_regs_t next_r;
	logic ext_s1;
	logic ext_s2;
	logic ext_low;
	logic ext_rise;
	logic any_reset;
	logic tri_window_met;

	function automatic logic rbseq_in_reset(input rbseq_pkg::rbseq_state_t st);
		rbseq_in_reset = (st == rbseq_pkg::rbseq_st_reset);
	endfunction

	// R1 pin low clears the synchroniser at once
	// kept apart from the main state so strap history survives the pin reset
	always_ff @(posedge clk_sys or posedge rst or negedge ext_reset_n)
	begin
		if (rst || !ext_reset_n)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
		end
		else if (clk_en)
		begin
			ext_s1 <= 1'b1;
			ext_s2 <= ext_s1;
		end
	end

	// R1 release seen only through two flops
	assign ext_low = ~ext_s2;

	// R7 external or watchdog, external release still resamples
	assign any_reset = ext_low | watchdog_unit_reset;

	// R13 release edge of the synchronised pin
	assign ext_rise = ext_s2 & ~r.ext_prev;

	// R8 ten consecutive low cycles seen
	assign tri_window_met = (r.tri_low_cnt == rbseq_pkg::win_full);

	always_comb
	begin
		next_r = r;
		next_r.tri_s1 = tristate_strap_n;
		next_r.tri_s2 = r.tri_s1;
		next_r.bw_s1 = boot_width_strap;
		next_r.bw_s2 = r.bw_s1;
		next_r.ext_prev = ext_s2;
		next_r.fetch = 1'b0;

		if (ext_low)
		begin
			// R8 count consecutive low cycles
			if (r.tri_s2)
			begin
				next_r.tri_low_cnt = rbseq_pkg::win_zero;
			end
			else if (!tri_window_met)
			begin
				next_r.tri_low_cnt = r.tri_low_cnt + rbseq_pkg::win_one;
			end
			// R11 last level before release
			next_r.bw_last = r.bw_s2;
		end
		else
		begin
			// stale count must not leak into the next reset
			next_r.tri_low_cnt = rbseq_pkg::win_zero;
		end

		// R13 modes change only on external release
		if (ext_rise)
		begin
			// R8 latch tri-state mode
			next_r.tri_mode = tri_window_met;
			// R11 latch boot width
			next_r.bw_mode = r.bw_last;
		end

		case (r.st)
			rbseq_pkg::rbseq_st_reset:
			begin
				next_r.cnt = rbseq_pkg::cnt_zero;
				if (!any_reset)
				begin
					next_r.st = rbseq_pkg::rbseq_st_wait;
					if (ext_rise)
					begin
						// R3 pin rose three edges ago
						next_r.cnt = rbseq_pkg::cnt_release;
					end
					else
					begin
						// R6 watchdog exit keeps modes
						next_r.cnt = rbseq_pkg::cnt_one;
					end
				end
			end
			rbseq_pkg::rbseq_st_wait:
			begin
				next_r.cnt = r.cnt + rbseq_pkg::cnt_one;
				// R3 eighty cycles to fetch
				if (r.cnt == rbseq_pkg::cnt_fetch - rbseq_pkg::cnt_one)
				begin
					next_r.fetch = 1'b1;
					next_r.st = rbseq_pkg::rbseq_st_run;
				end
			end
			rbseq_pkg::rbseq_st_run:
			begin
				next_r.st = rbseq_pkg::rbseq_st_run;
			end
			default:
			begin
				next_r.st = rbseq_pkg::rbseq_st_reset;
			end
		endcase

		if (!rbseq_in_reset(r.st) && remap_cmd)
		begin
			next_r.remap = 1'b1;
		end

		// R4 software may take the pin back
		if (!rbseq_in_reset(r.st) && clk_out_reassign)
		begin
			next_r.clk_gate = 1'b0;
		end
		else if (r.st == rbseq_pkg::rbseq_st_wait)
		begin
			next_r.clk_gate = 1'b1;
		end

		// R6 same effect for watchdog and pin
		if (any_reset)
		begin
			next_r.st = rbseq_pkg::rbseq_st_reset;
			next_r.cnt = rbseq_pkg::cnt_zero;
			// R12 remap cleared by reset
			next_r.remap = 1'b0;
			next_r.clk_gate = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.st <= rbseq_pkg::rbseq_st_reset;
			r.tri_s1 <= 1'b1;
			r.tri_s2 <= 1'b1;
		end
		else if (clk_en)
		begin
			r <= next_r;
		end
	end

	// R4 gated clock copy, low at once in pin reset, from the next edge in watchdog reset
	assign master_clk_out = r.clk_gate & ext_s2 & clk_sys;

	// R5 peripherals held during any reset
	assign periph_reset = rbseq_in_reset(r.st) | any_reset;

	assign fetch_start = r.fetch;

	// R5 fetch vector zero
	assign fetch_addr_zero = 1'b1;

	// R10 pins inputs through reset and the wait state, until the first fetch
	assign pins_as_inputs = periph_reset | (r.st == rbseq_pkg::rbseq_st_wait);

	assign remap_active = r.remap;

	assign tristate_mode = r.tri_mode;

	assign boot_8bit = r.bw_mode;

endmodule

// ### verilog/rbseq_pkg.sv
package rbseq_pkg;
	localparam int unsigned clk_period_ns = 8;
	localparam int unsigned strap_window_cycles = 10;
	localparam int unsigned first_fetch_cycles = 80;
	localparam int unsigned cnt_w = 7;
	localparam logic [6:0] cnt_zero = 7'h00;
	localparam logic [6:0] cnt_one = 7'h01;
	localparam logic [6:0] cnt_fetch = 7'(first_fetch_cycles);
	localparam logic [6:0] cnt_release = 7'h03;
	localparam logic [3:0] win_full = 4'(strap_window_cycles);
	localparam logic [3:0] win_zero = 4'h0;
	localparam logic [3:0] win_one = 4'h1;

	typedef enum logic [1:0] {
		rbseq_st_reset = 2'b00,
		rbseq_st_wait = 2'b01,
		rbseq_st_run = 2'b11
	} rbseq_state_t;
endpackage

// ### tb/rbseq_board.sv
`timescale 1ns/10ps
module rbseq_board (
	input wire logic hold,
	input wire logic dbg,
	input wire logic bw,
	output logic ext_reset_n,
	output logic tristate_strap_n,
	output logic boot_width_strap
);
	assign ext_reset_n = ~hold;
	assign tristate_strap_n = ~dbg;
	assign boot_width_strap = bw;
endmodule

// ### tb/rbseq_top_asserts.sv
`timescale 1ns/10ps
module rbseq_top_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ext_reset_n,
	input wire logic watchdog_unit_reset,
	input wire logic periph_reset,
	input wire logic fetch_start,
	input wire logic fetch_addr_zero,
	input wire logic pins_as_inputs,
	input wire logic tristate_mode,
	input wire logic boot_8bit,
	input wire logic remap_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_in; !ext_reset_n |-> periph_reset && pins_as_inputs; endproperty
	a_in: assert property (p_in) else $error("reset entry");
	property p_sync; $rose(ext_reset_n) |-> periph_reset; endproperty
	a_sync: assert property (p_sync) else $error("release");
	property p_fetch; $rose(ext_reset_n) && !watchdog_unit_reset |-> ##80 fetch_start;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch");
	property p_pulse; fetch_start |=> !fetch_start; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_addr; fetch_addr_zero; endproperty
	a_addr: assert property (p_addr) else $error("addr");
	property p_wdog; watchdog_unit_reset |-> periph_reset; endproperty
	a_wdog: assert property (p_wdog) else $error("wdog");
	property p_keep; watchdog_unit_reset && ext_reset_n && $past(ext_reset_n, 3)
		|=> $stable({tristate_mode, boot_8bit});
	endproperty
	a_keep: assert property (p_keep) else $error("modes");
	property p_remap; watchdog_unit_reset || !ext_reset_n |=> !remap_active; endproperty
	a_remap: assert property (p_remap) else $error("remap");
endmodule
bind rbseq_top rbseq_top_asserts i_chk (.clk_sys, .rst, .ext_reset_n, .watchdog_unit_reset,
	.periph_reset, .fetch_start, .fetch_addr_zero, .pins_as_inputs, .tristate_mode,
	.boot_8bit, .remap_active);

// ### tb/rbseq_top_tb.sv
`timescale 1ns/10ps
module rbseq_top_tb;
	logic clk_sys = 1'h0, rst = 1'h1, hold = 1'h1, dbg = 1'h0, bw = 1'h1;
	logic watchdog_unit_reset = 1'h0, remap_cmd = 1'h0;
	logic ext_reset_n, tristate_strap_n, boot_width_strap;
	logic fetch_start, tristate_mode, boot_8bit, remap_active;
	logic master_clk_out, periph_reset, pins_as_inputs, fetch_addr_zero;
	logic clk_out_reassign = 1'h0;
	int bad_count = 0, check_count = 0;
	initial forever #4 clk_sys = ~clk_sys;
	rbseq_board i_brd (.hold, .dbg, .bw, .ext_reset_n, .tristate_strap_n, .boot_width_strap);
	rbseq_top i_dut (.clk_sys, .rst, .clk_en(1'h1), .ext_reset_n, .tristate_strap_n,
		.boot_width_strap, .watchdog_unit_reset, .remap_cmd, .clk_out_reassign,
		.master_clk_out, .periph_reset, .fetch_start, .fetch_addr_zero,
		.tristate_mode, .boot_8bit, .remap_active, .pins_as_inputs);
	task chk(input string n, input logic v, input logic e);
		check_count++;
		if (v !== e)
		begin
			bad_count++;
			$display("[ERR] %s exp %b got %b", n, e, v);
		end
	endtask
	task report_and_stop;
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task boot(input logic d, input logic b);
		int n;
		hold = 1'h1;
		dbg = d;
		bw = b;
		repeat (19) @(negedge clk_sys);
		@(posedge clk_sys);
		#1;
		chk("clk_out", master_clk_out, 1'h0);
		chk("periph", periph_reset, 1'h1);
		chk("inputs", pins_as_inputs, 1'h1);
		@(negedge clk_sys);
		hold = 1'h0;
		n = 0;
		while (fetch_start !== 1'h1 && n < 200)
		begin
			@(negedge clk_sys);
			n++;
		end
		chk("fetch", n == 80, 1'h1);
		if (n >= 200)
			report_and_stop();
		chk("tri", tristate_mode, d);
		chk("bw", boot_8bit, b);
		chk("addr", fetch_addr_zero, 1'h1);
		@(posedge clk_sys);
		#1;
		chk("clk_out", master_clk_out, 1'h1);
		@(negedge clk_sys);
		chk("pulse", fetch_start, 1'h0);
		chk("inputs", pins_as_inputs, 1'h0);
		$display("boot done");
	endtask
	task wdog;
		remap_cmd = 1'h1;
		dbg = 1'h1;
		bw = 1'h0;
		@(negedge clk_sys);
		remap_cmd = 1'h0;
		chk("remap", remap_active, 1'h1);
		watchdog_unit_reset = 1'h1;
		repeat (12) @(negedge clk_sys);
		chk("remap", remap_active, 1'h0);
		chk("tri", tristate_mode, 1'h0);
		chk("bw", boot_8bit, 1'h1);
		hold = 1'h1;
		repeat (12) @(negedge clk_sys);
		hold = 1'h0;
		watchdog_unit_reset = 1'h0;
		repeat (5) @(negedge clk_sys);
		chk("tri", tristate_mode, 1'h1);
		chk("bw", boot_8bit, 1'h0);
		repeat (90) @(negedge clk_sys);
		clk_out_reassign = 1'h1;
		@(posedge clk_sys);
		#1;
		chk("clk_out", master_clk_out, 1'h0);
		@(negedge clk_sys);
		$display("wdog done");
	endtask
	initial
	begin
		repeat (20) @(negedge clk_sys);
		rst = 1'h0;
		boot(1'h1, 1'h0);
		boot(1'h0, 1'h1);
		wdog();
		report_and_stop();
	end
endmodule
